// ==== hdl/dio_pkg.sv ====
/*
  Package for the digital channel port with edge logger: register indices,
  field widths, reset values and timing constants.
  Assumes a single 50 MHz clock domain.
*/
package dio_pkg;
  localparam int unsigned CLK_MHZ        = 50;
  localparam int unsigned SAMPLE_NS      = 10;
  localparam int unsigned CLK_PERIOD_NS  = 1000 / CLK_MHZ;
  // Sampling cannot be faster than the clock; least one cycle
  localparam int unsigned SAMPLE_CYC     = (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TIMER_MHZ      = 100;
  localparam logic [31:0] TS_STEP        = 32'(TIMER_MHZ / CLK_MHZ);
  localparam int unsigned NCH            = 32;
  localparam int unsigned GRP            = 8;
  localparam int unsigned NGRP           = NCH / GRP;
  localparam int unsigned FIFO_DEPTH     = 511;
  localparam int unsigned FIFO_AW        = 9;
  localparam logic [3:0]  DIR_RESET      = 4'h0;

  localparam logic [7:0] A_DIR        = 8'h00;
  localparam logic [7:0] A_IN_ALL     = 8'h04;
  localparam logic [7:0] A_IN_LO      = 8'h08;
  localparam logic [7:0] A_IN_HI      = 8'h0c;
  localparam logic [7:0] A_OUT_ALL    = 8'h10;
  localparam logic [7:0] A_OUT_LO     = 8'h14;
  localparam logic [7:0] A_OUT_HI     = 8'h18;
  localparam logic [7:0] A_OUT_SET    = 8'h1c;
  localparam logic [7:0] A_OUT_CLR    = 8'h20;
  localparam logic [7:0] A_OUT_BIT    = 8'h24;
  localparam logic [7:0] A_EDGE       = 8'h28;
  localparam logic [7:0] A_SEL        = 8'h2c;
  localparam logic [7:0] A_FCTL       = 8'h30;
  localparam logic [7:0] A_FSTAT      = 8'h34;
  localparam logic [7:0] A_FLEVEL     = 8'h38;
  localparam logic [7:0] A_FTIME      = 8'h3c;
  localparam logic [7:0] A_EVCTL      = 8'h40;
  localparam logic [7:0] A_IRQ_STAT   = 8'h44;
  localparam logic [7:0] A_IRQ_MASK   = 8'h48;

  localparam int unsigned FCTL_EN     = 0;
  localparam int unsigned FCTL_CLR    = 1;
  localparam int unsigned IRQ_EVENT   = 0;
  localparam int unsigned IRQ_CHANGE  = 1;
  localparam int unsigned IRQ_FULL    = 2;
  localparam int unsigned IRQ_W       = 3;
  localparam int unsigned BIT_VAL     = 5;

  typedef enum logic [1:0]
  {
    EV_NONE  = 2'b00,
    EV_EXT   = 2'b01,
    EV_OTHER = 2'b10
  } dio_evsrc_e;
endpackage : dio_pkg

// ==== hdl/dio_sync.sv ====
/*
  Three-stage input synchroniser with agreement filter.
  Assumes an asynchronous input and a single clock.
*/
`timescale 1ns/10ps
`default_nettype none
module dio_sync #(parameter int unsigned W = 1)
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      dout <= '0;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Only a change seen in two stages counts
      for (int i = 0; i < W; i++)
        if (s2_q[i] == s3_q[i])
          dout[i] <= s3_q[i];
    end
  end
endmodule : dio_sync
`default_nettype wire

// ==== hdl/dio_fifo.sv ====
/*
  Change-log FIFO of level/timestamp pairs in flip-flops.
  Assumes the writer checks full; a push while full is dropped.
*/
`timescale 1ns/10ps
`default_nettype none
module dio_fifo
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clr,
  // Write side
  input  wire logic        push,
  input  wire logic [31:0] wlevel,
  input  wire logic [31:0] wtime,
  // Read side
  input  wire logic        pop,
  output logic      [31:0] rlevel,
  output logic      [31:0] rtime,
  output logic             full,
  output logic             empty,
  output logic      [9:0]  count
);
  logic [31:0] lvl_mem [dio_pkg::FIFO_DEPTH];
  logic [31:0] ts_mem  [dio_pkg::FIFO_DEPTH];
  logic [dio_pkg::FIFO_AW-1:0] wp_q;
  logic [dio_pkg::FIFO_AW-1:0] rp_q;
  logic do_push;
  logic do_pop;

  function automatic logic [dio_pkg::FIFO_AW-1:0] nxt(input logic [dio_pkg::FIFO_AW-1:0] p);
    nxt = (p == dio_pkg::FIFO_AW'(dio_pkg::FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : nxt

  assign full    = (count == 10'(dio_pkg::FIFO_DEPTH));
  assign empty   = (count == '0);
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;
  assign rlevel  = lvl_mem[rp_q];
  assign rtime   = ts_mem[rp_q];

  always_ff @(posedge clk)
  begin
    if (do_push)
    begin
      lvl_mem[wp_q] <= wlevel;
      ts_mem[wp_q]  <= wtime;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      count <= '0;
    end
    else if (clr)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      count <= '0;
    end
    else
    begin
      if (do_push)
        wp_q <= nxt(wp_q);
      if (do_pop)
        rp_q <= nxt(rp_q);
      count <= count + 10'(do_push) - 10'(do_pop);
    end
  end
endmodule : dio_fifo
`default_nettype wire

// ==== hdl/dio_top.sv ====
/*
  Digital channel port: 32 channels in four direction groups, external
  trigger, change logger with timestamp FIFO, sticky edge flags, interrupt.
  Assumes a plain register port, one clock, pins outside the clock domain.
*/
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - 32 channels, direction set per group of eight.
// - After reset all four groups are inputs.
// - Direction word bit k makes group k an output.
// - Rising trigger edge raises an event; only one source active.
// - Selected inputs compared every 10 ns for changes; the code compares once per 20 ns clock cycle.
// - Each change pushes level pattern then timestamp of 100 MHz timer.
// - FIFO holds 511 pairs in chronological order.
// - FIFO clear, enable, full status, separate level and time reads.
// - Any edge sets that channel's sticky flag; the code flags channels in input groups only.
// - Reading edge flags returns them and clears all.
// - Inputs readable as full word or either half.
// - Driven outputs readable as word or halves.
module dio_top
(
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // Register port
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  // Channel pins
  input  wire logic [31:0] CH_IN,
  output logic      [31:0] CH_OUT,
  output logic      [31:0] CH_OE,
  // Trigger
  input  wire logic        TRIG_IN,
  output logic             EVENT_PULSE,
  // Interrupt
  output logic             IRQ
);
  logic [3:0]  dir_q;
  logic [31:0] out_q;
  logic [31:0] sel_q;
  logic [31:0] edge_q;
  logic        fen_q;
  logic [1:0]  evsrc_q;
  logic [dio_pkg::IRQ_W-1:0] ist_q;
  logic [dio_pkg::IRQ_W-1:0] imsk_q;
  logic [31:0] ts_q;
  logic [31:0] prev_q;
  logic [31:0] dir_prev_q;
  logic [7:0]  scnt_q;
  logic        trig_prev_q;
  logic [31:0] in_s;
  logic        trig_s;
  logic [31:0] dir_mask;
  logic [31:0] inp;
  logic [31:0] watch;
  logic        tick;
  logic        change;
  logic        fclr;
  logic        fpush;
  logic        fpop;
  logic [31:0] f_level;
  logic [31:0] f_time;
  logic        f_full;
  logic        f_empty;
  logic [9:0]  f_count;
  logic        trig_rise;
  logic        edge_rd;
  logic [31:0] rd_d;

  function automatic logic wr_at(input logic [7:0] a);
    wr_at = WR && (ADDR == a);
  endfunction : wr_at

  dio_sync #(.W(33)) u_sync
  (
    .clk  (CLOCK),
    .rst  (RST),
    .din  ({TRIG_IN, CH_IN}),
    .dout ({trig_s, in_s})
  );

  // Group direction expands to one enable per channel
  genvar g;
  generate
    for (g = 0; g < dio_pkg::NGRP; g++)
    begin : g_dir
      assign dir_mask[g*dio_pkg::GRP +: dio_pkg::GRP] = {dio_pkg::GRP{dir_q[g]}};
    end
  endgenerate

  // Output channels read back their driven value
  assign inp = (in_s & ~dir_mask) | (out_q & dir_mask);

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      dir_q <= dio_pkg::DIR_RESET;
    else if (wr_at(dio_pkg::A_DIR))
      dir_q <= WDATA[3:0];
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      out_q <= '0;
    else if (WR)
    begin
      case (ADDR)
        dio_pkg::A_OUT_ALL: out_q <= WDATA;
        dio_pkg::A_OUT_LO:  out_q[15:0] <= WDATA[15:0];
        dio_pkg::A_OUT_HI:  out_q[31:16] <= WDATA[15:0];
        dio_pkg::A_OUT_SET: out_q <= out_q | WDATA;
        dio_pkg::A_OUT_CLR: out_q <= out_q & ~WDATA;
        dio_pkg::A_OUT_BIT: out_q[WDATA[4:0]] <= WDATA[dio_pkg::BIT_VAL];
        default:            out_q <= out_q;
      endcase
    end
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      CH_OUT <= '0;
      CH_OE  <= '0;
    end
    else
    begin
      CH_OUT <= out_q & dir_mask;
      CH_OE  <= dir_mask;
    end
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      sel_q   <= '0;
      fen_q   <= 1'b0;
      evsrc_q <= dio_pkg::EV_NONE;
      imsk_q  <= '0;
    end
    else if (WR)
    begin
      if (ADDR == dio_pkg::A_SEL)
        sel_q <= WDATA;
      if (ADDR == dio_pkg::A_FCTL)
        fen_q <= WDATA[dio_pkg::FCTL_EN];
      if (ADDR == dio_pkg::A_EVCTL)
        evsrc_q <= WDATA[1:0];
      if (ADDR == dio_pkg::A_IRQ_MASK)
        imsk_q <= WDATA[dio_pkg::IRQ_W-1:0];
    end
  end

  // Free-running timestamp in 100 MHz units
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      ts_q <= '0;
    else
      ts_q <= ts_q + dio_pkg::TS_STEP;
  end

  // The clock is slower than the sample period, so every cycle samples
  assign tick = (scnt_q == 8'(dio_pkg::SAMPLE_CYC - 1));

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      scnt_q <= '0;
    else
      scnt_q <= tick ? '0 : scnt_q + 8'h01;
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      prev_q <= '0;
    else if (tick)
      prev_q <= inp;
  end

  // A group just turned to input still holds its driven level in prev_q;
  // its first sample is skipped so the turn is not logged as a pin change
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      dir_prev_q <= '0;
    else if (tick)
      dir_prev_q <= dir_mask;
  end

  assign watch = ~dir_mask & ~dir_prev_q;

  assign change = tick && fen_q && (((inp ^ prev_q) & sel_q & watch) != '0);
  assign fclr   = wr_at(dio_pkg::A_FCTL) && WDATA[dio_pkg::FCTL_CLR];
  assign fpush  = change;
  assign fpop   = RD && (ADDR == dio_pkg::A_FTIME);

  dio_fifo u_fifo
  (
    .clk    (CLOCK),
    .rst    (RST),
    .clr    (fclr),
    .push   (fpush),
    .wlevel (inp),
    .wtime  (ts_q),
    .pop    (fpop),
    .rlevel (f_level),
    .rtime  (f_time),
    .full   (f_full),
    .empty  (f_empty),
    .count  (f_count)
  );

  // Flags from edges win over the clear in the same cycle
  assign edge_rd = RD && (ADDR == dio_pkg::A_EDGE);

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      edge_q <= '0;
    else
      edge_q <= (edge_rd ? '0 : edge_q) | ((in_s ^ prev_q) & watch & {32{tick}});
  end

  // Detector resets low like the idle pin, so no false edge follows reset
  assign trig_rise = trig_s && !trig_prev_q;

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      trig_prev_q <= 1'b0;
      EVENT_PULSE <= 1'b0;
    end
    else
    begin
      trig_prev_q <= trig_s;
      EVENT_PULSE <= trig_rise && (evsrc_q == dio_pkg::EV_EXT);
    end
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      ist_q <= '0;
    else
    begin
      // A new event wins over a write-one-to-clear in the same cycle
      ist_q[dio_pkg::IRQ_EVENT] <= (trig_rise && (evsrc_q == dio_pkg::EV_EXT))
        || (ist_q[dio_pkg::IRQ_EVENT] && !(wr_at(dio_pkg::A_IRQ_STAT) && WDATA[dio_pkg::IRQ_EVENT]));
      ist_q[dio_pkg::IRQ_CHANGE] <= change
        || (ist_q[dio_pkg::IRQ_CHANGE] && !(wr_at(dio_pkg::A_IRQ_STAT) && WDATA[dio_pkg::IRQ_CHANGE]));
      ist_q[dio_pkg::IRQ_FULL] <= (change && f_full)
        || (ist_q[dio_pkg::IRQ_FULL] && !(wr_at(dio_pkg::A_IRQ_STAT) && WDATA[dio_pkg::IRQ_FULL]));
    end
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      IRQ <= 1'b0;
    else
      IRQ <= |(ist_q & imsk_q);
  end

  always_comb
  begin
    rd_d = '0;
    case (ADDR)
      dio_pkg::A_DIR:      rd_d = {28'h0000000, dir_q};
      dio_pkg::A_IN_ALL:   rd_d = inp;
      dio_pkg::A_IN_LO:    rd_d = {16'h0000, inp[15:0]};
      dio_pkg::A_IN_HI:    rd_d = {16'h0000, inp[31:16]};
      dio_pkg::A_OUT_ALL:  rd_d = out_q;
      dio_pkg::A_OUT_LO:   rd_d = {16'h0000, out_q[15:0]};
      dio_pkg::A_OUT_HI:   rd_d = {16'h0000, out_q[31:16]};
      dio_pkg::A_EDGE:     rd_d = edge_q;
      dio_pkg::A_SEL:      rd_d = sel_q;
      dio_pkg::A_FCTL:     rd_d = {31'h00000000, fen_q};
      dio_pkg::A_FSTAT:    rd_d = {20'h00000, f_count, f_empty, f_full};
      dio_pkg::A_FLEVEL:   rd_d = f_level;
      dio_pkg::A_FTIME:    rd_d = f_time;
      dio_pkg::A_EVCTL:    rd_d = {30'h00000000, evsrc_q};
      dio_pkg::A_IRQ_STAT: rd_d = {29'h00000000, ist_q};
      dio_pkg::A_IRQ_MASK: rd_d = {29'h00000000, imsk_q};
      default:             rd_d = '0;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      RDATA <= '0;
    else
      RDATA <= RD ? rd_d : '0;
  end
endmodule : dio_top
`default_nettype wire

// ==== bench/dio_field.sv ====
/*
  Field side model of the channel pins.
  Assumes CH_OE high while the port drives a channel.
*/
`timescale 1ns/10ps
`default_nettype none
module dio_field
(
  // Port side
  input  wire logic [31:0] oe,
  input  wire logic [31:0] drv,
  // Field side
  input  wire logic [31:0] ext,
  output logic      [31:0] pin
);
  // A driven channel shows the port level; the rest follow the field
  assign pin = (oe & drv) | (~oe & ext);
endmodule : dio_field
`default_nettype wire

// ==== bench/dio_checker.sv ====
/*
  Port checker for dio_top.
  Assumes the master keeps the register port contract.
*/
`timescale 1ns/10ps
`default_nettype none
module dio_checker
(
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        RST,
  // Register port
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  // Pins
  input wire logic [31:0] CH_OUT,
  input wire logic [31:0] CH_OE,
  input wire logic        TRIG_IN,
  input wire logic        EVENT_PULSE,
  input wire logic        IRQ
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  AST_OE_GROUP: assert property (CH_OE == {{8{CH_OE[31]}}, {8{CH_OE[23]}}, {8{CH_OE[15]}}, {8{CH_OE[7]}}})
    else $error("enable not whole groups");
  AST_RST_IN: assert property (disable iff (1'b0) RST && $past(RST) |-> CH_OE == 32'h0 && CH_OUT == 32'h0)
    else $error("pins driven in reset");
  AST_OUT_MASK: assert property ((CH_OUT & ~CH_OE) == 32'h0)
    else $error("input group driven");
  AST_DIR_WRITE: assert property (WR && ADDR == dio_pkg::A_DIR |-> ##2 CH_OE == {{8{$past(WDATA[3], 2)}},
    {8{$past(WDATA[2], 2)}}, {8{$past(WDATA[1], 2)}}, {8{$past(WDATA[0], 2)}}}) else $error("direction wrong");
  AST_OUT_WRITE: assert property (WR && ADDR == dio_pkg::A_OUT_ALL |-> ##2 CH_OUT == ($past(WDATA, 2) & CH_OE))
    else $error("output word wrong");
  AST_READBACK: assert property (RD && ADDR == dio_pkg::A_OUT_ALL && CH_OE == 32'hffffffff |=> RDATA == CH_OUT)
    else $error("readback wrong");
  AST_IN_HALF: assert property (RD && ADDR == dio_pkg::A_IN_HI |=> RDATA[31:16] == 16'h0)
    else $error("half read wide");
  AST_EVT_ONE: assert property (EVENT_PULSE |=> !EVENT_PULSE)
    else $error("event pulse long");
  AST_EVT_CAUSE: assert property (EVENT_PULSE |-> $past(TRIG_IN, 2) || $past(TRIG_IN, 3) || $past(TRIG_IN, 4))
    else $error("event without trigger");
  AST_IRQ_MASK: assert property (WR && ADDR == dio_pkg::A_IRQ_MASK && WDATA == 32'h0 |-> ##2 !IRQ)
    else $error("masked interrupt high");
  COV_EVT: cover property (EVENT_PULSE);
  COV_POP: cover property (RD && ADDR == dio_pkg::A_FTIME);
  COV_IRQ: cover property ($rose(IRQ));
endmodule : dio_checker
bind dio_top dio_checker dio_checker_inst
(
  .CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .CH_OUT(CH_OUT), .CH_OE(CH_OE), .TRIG_IN(TRIG_IN), .EVENT_PULSE(EVENT_PULSE), .IRQ(IRQ)
);
`default_nettype wire

// ==== bench/tb.sv ====
/*
  Register level testbench for dio_top.
  Assumes the field model dio_field and a 50 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        CLOCK;
  logic        RST;
  logic [7:0]  ADDR;
  logic [31:0] WDATA;
  logic        WR;
  logic        RD;
  logic        TRIG_IN;
  logic [31:0] ext;
  logic [31:0] d;
  logic [31:0] t1;
  wire  [31:0] RDATA;
  wire  [31:0] CH_IN;
  wire  [31:0] CH_OUT;
  wire  [31:0] CH_OE;
  wire         EVENT_PULSE;
  wire         IRQ;
  int          err_total;
  int          compares;
  int          i;
  localparam logic [7:0]  TA [7] = '{dio_pkg::A_OUT_ALL, dio_pkg::A_OUT_LO, dio_pkg::A_OUT_HI,
    dio_pkg::A_OUT_SET, dio_pkg::A_OUT_CLR, dio_pkg::A_OUT_BIT, dio_pkg::A_OUT_BIT};
  localparam logic [31:0] TD [7] = '{32'h12345678, 32'habcd, 32'h5a5a, 32'hf0, 32'h5a000000, 32'h3f, 32'h0};
  localparam logic [31:0] TE [7] = '{32'h12345678, 32'h1234abcd, 32'h5a5aabcd, 32'h5a5aabfd, 32'h005aabfd,
    32'h805aabfd, 32'h805aabfc};

  dio_top dio_top_inst
  (
    .CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .CH_IN(CH_IN), .CH_OUT(CH_OUT), .CH_OE(CH_OE), .TRIG_IN(TRIG_IN), .EVENT_PULSE(EVENT_PULSE), .IRQ(IRQ)
  );
  dio_field dio_field_inst (.oe(CH_OE), .drv(CH_OUT), .ext(ext), .pin(CH_IN));

  always #10 CLOCK = ~CLOCK;

  task automatic end_of_test;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Ends 1 ns past the edge so registered outputs have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLOCK);
    ADDR  <= a;
    WDATA <= v;
    WR    <= 1'b1;
    @(posedge CLOCK);
    WR    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge CLOCK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLOCK);
    RD   <= 1'b0;
    #1;
    v = RDATA;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
  endtask : rc

  task automatic flip(input logic [31:0] m);
    @(posedge CLOCK);
    ext <= ext ^ m;
  endtask : flip

  initial
  begin
    CLOCK   = 1'b0;
    RST     = 1'b1;
    ADDR    = 8'h0;
    WDATA   = 32'h0;
    WR      = 1'b0;
    RD      = 1'b0;
    TRIG_IN = 1'b0;
    ext     = 32'h0;
    err_total = 0;
    compares  = 0;
    repeat (20) @(posedge CLOCK);
    RST <= 1'b0;
    rc(dio_pkg::A_DIR, 32'h0);
    chk(CH_OE, 32'h0);
    for (i = 0; i < 16; i++)
    begin
      wr(dio_pkg::A_DIR, 32'(i));
      cyc(1);
      chk(CH_OE, {{8{i[3]}}, {8{i[2]}}, {8{i[1]}}, {8{i[0]}}});
    end
    for (i = 0; i < 7; i++)
    begin
      wr(TA[i], TD[i]);
      cyc(1);
      chk(CH_OUT, TE[i]);
      rc(dio_pkg::A_OUT_ALL, TE[i]);
    end
    rc(dio_pkg::A_OUT_LO, 32'habfc);
    rc(dio_pkg::A_OUT_HI, 32'h805a);
    wr(dio_pkg::A_DIR, 32'hc);
    ext <= 32'hffffc3a5;
    cyc(6);
    rc(dio_pkg::A_IN_ALL, 32'h805ac3a5);
    rc(dio_pkg::A_IN_LO, 32'hc3a5);
    rc(dio_pkg::A_IN_HI, 32'h805a);
    rd(dio_pkg::A_EDGE, d);
    flip(32'h00010101);
    cyc(6);
    rc(dio_pkg::A_EDGE, 32'h0101);
    rc(dio_pkg::A_EDGE, 32'h0);
    wr(dio_pkg::A_SEL, 32'hffff);
    wr(dio_pkg::A_FCTL, 32'h2);
    wr(dio_pkg::A_FCTL, 32'h1);
    rc(dio_pkg::A_FSTAT, 32'h2);
    flip(32'h1);
    repeat (9) @(posedge CLOCK);
    flip(32'h2);
    cyc(6);
    rc(dio_pkg::A_FSTAT, 32'h8);
    rc(dio_pkg::A_FLEVEL, 32'h805ac2a5);
    rd(dio_pkg::A_FTIME, t1);
    rc(dio_pkg::A_FLEVEL, 32'h805ac2a7);
    rd(dio_pkg::A_FTIME, d);
    chk(d - t1, dio_pkg::TS_STEP * 32'd10);
    wr(dio_pkg::A_FCTL, 32'h0);
    flip(32'h4);
    cyc(6);
    rc(dio_pkg::A_FSTAT, 32'h2);
    wr(dio_pkg::A_FCTL, 32'h1);
    for (i = 0; i < 520; i++)
    begin
      flip(32'h1);
      repeat (2) @(posedge CLOCK);
    end
    cyc(6);
    rc(dio_pkg::A_FSTAT, 32'h7fd);
    rc(dio_pkg::A_IRQ_STAT, 32'h6);
    rc(dio_pkg::A_FLEVEL, 32'h805ac2a2);
    rd(dio_pkg::A_FTIME, d);
    rc(dio_pkg::A_FSTAT, 32'h7f8);
    wr(dio_pkg::A_FCTL, 32'h2);
    rc(dio_pkg::A_FSTAT, 32'h2);
    wr(dio_pkg::A_IRQ_STAT, 32'h7);
    wr(dio_pkg::A_IRQ_MASK, 32'h1);
    wr(dio_pkg::A_EVCTL, 32'h1);
    TRIG_IN <= 1'b1;
    for (i = 0; i < 20 && EVENT_PULSE !== 1'b1; i++)
      cyc(1);
    if (EVENT_PULSE !== 1'b1)
    begin
      err_total++;
      end_of_test();
    end
    @(posedge CLOCK);
    TRIG_IN <= 1'b0;
    cyc(2);
    chk(IRQ, 1'b1);
    rc(dio_pkg::A_IRQ_STAT, 32'h1);
    wr(dio_pkg::A_IRQ_MASK, 32'h0);
    cyc(1);
    chk(IRQ, 1'b0);
    wr(dio_pkg::A_IRQ_MASK, 32'h1);
    cyc(1);
    chk(IRQ, 1'b1);
    wr(dio_pkg::A_IRQ_STAT, 32'h1);
    cyc(1);
    chk(IRQ, 1'b0);
    wr(dio_pkg::A_EVCTL, 32'h0);
    TRIG_IN <= 1'b1;
    repeat (8) @(posedge CLOCK);
    TRIG_IN <= 1'b0;
    rc(dio_pkg::A_IRQ_STAT, 32'h0);
    rc(8'h80, 32'h0);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
